// ==== slpwm_host.sv ====
// microcomputer model driving the three-wire serial bus
`timescale 1ns/1ns
module slpwm_host (
  // serial link
  output logic o_burst_clock,
  output logic o_transfer_enable,
  output logic o_data
);
  initial begin
    o_burst_clock = 1'b0;
    o_transfer_enable = 1'b0;
    o_data = 1'b0;
  end
  // clock stands still between words; n may be off twelve on purpose
  task automatic send(input logic [11:0] w, input int n);
    o_transfer_enable = 1'b1;
    // data moves a little after the falling edge so the sample never races
    for (int i = 0; i < n; i++) begin
      #1 o_data = w[i % 12];
      #2 o_burst_clock = 1'b1;
      #3 o_burst_clock = 1'b0;
    end
    // released line shows the inverse, not a stale bit
    #1 o_data = ~o_data;
    #2 o_transfer_enable = 1'b0;
    #3 o_burst_clock = 1'b1;
    #3 o_burst_clock = 1'b0;
  endtask
endmodule

// ==== slpwm_pkg.sv ====
// constants for the serial-loaded six-channel pwm block
// Function
// - bits shift only while transfer enable is high for the whole word
// - burst clock pulse with enable low loads the word if all checks pass
// - accept only words of exactly twelve burst clock pulses
// - first bit is a start bit; high start bit rejects the word
// - device address bits must equal the two address pins
// - word is start bit, two address, three channel, six level bits
// - channel codes 1 to 6 select channels; 0 and 7 load nothing
// - each output pattern repeats every 64 oscillator cycles
// - level v gives v+1 high cycles out of 64
// - internal reset: one cycle at power up, held while a supply disturbance lasts
// - after reset every level register holds 31
// - buffered copy of the oscillator clock on its own output
package slpwm_pkg;
  localparam int WORD_BITS = 12;
  localparam logic [3:0] WORD_BITS_C = 4'hc;
  localparam int START_POS = 0;
  localparam int ADDR_A_POS = 1;
  localparam int ADDR_B_POS = 2;
  localparam int CHAN_LSB = 3;
  localparam int CHAN_W = 3;
  localparam int LEVEL_LSB = 6;
  localparam int LEVEL_W = 6;
  localparam int NUM_CHAN = 6;
  localparam logic [5:0] LEVEL_RESET = 6'h1f;
  localparam logic [5:0] PERIOD_LAST = 6'h3f;
endpackage

// ==== slpwm_top.sv ====
// serial-loaded six-channel pwm level memory
`timescale 1ns/1ns
module slpwm_top (
  // oscillator and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_supply_glitch,
  // serial link
  input wire logic i_burst_clock,
  input wire logic i_transfer_enable,
  input wire logic i_data,
  // address straps
  input wire logic i_device_addr_pin_a,
  input wire logic i_device_addr_pin_b,
  // outputs
  output logic o_buffered_osc_out,
  output logic [5:0] o_level_output
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: burst clock falling edge samples data

  logic [11:0] shift_r;
  logic [3:0] count_r;
  logic over_r;
  logic load_tgl_r;
  logic [11:0] word_r;
  logic word_ok_r;
  logic enable_prev_r;

  // a second pulse with enable low loads nothing more, as enable_prev gates it
  always_ff @(negedge i_burst_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_r <= 12'h000;
      count_r <= 4'h0;
      over_r <= 1'b0;
      enable_prev_r <= 1'b0;
      load_tgl_r <= 1'b0;
      word_r <= 12'h000;
      word_ok_r <= 1'b0;
    end else begin
      enable_prev_r <= i_transfer_enable;
      if (i_transfer_enable) begin
        if (!enable_prev_r) begin
          shift_r <= {11'h000, i_data};
          count_r <= 4'h1;
          over_r <= 1'b0;
        end else begin
          if (count_r == slpwm_pkg::WORD_BITS_C) begin
            over_r <= 1'b1;
          end else begin
            shift_r[count_r] <= i_data;
            count_r <= count_r + 4'h1;
          end
        end
      end else if (enable_prev_r) begin
        word_r <= shift_r;
        word_ok_r <= (count_r == slpwm_pkg::WORD_BITS_C) && !over_r
          && !shift_r[slpwm_pkg::START_POS];
        load_tgl_r <= ~load_tgl_r;
      end
    end
  end

  // link checks sample on the same falling edge that shifts the data
  count_range_a: assert property (@(negedge i_burst_clock)
    disable iff (!i_arst_n)
    count_r <= slpwm_pkg::WORD_BITS_C)
    else $error("bit count beyond word length");

  frame_start_a: assert property (@(negedge i_burst_clock)
    disable iff (!i_arst_n)
    i_transfer_enable && !enable_prev_r |=> count_r == 4'h1)
    else $error("new word did not restart the bit count");

  over_flag_a: assert property (@(negedge i_burst_clock)
    disable iff (!i_arst_n)
    i_transfer_enable && enable_prev_r
    && count_r == slpwm_pkg::WORD_BITS_C |=> over_r)
    else $error("over-long word not flagged");

  idle_hold_a: assert property (@(negedge i_burst_clock)
    disable iff (!i_arst_n)
    !i_transfer_enable |=> $stable(shift_r) && $stable(count_r))
    else $error("bits shifted while enable low");

  load_word_a: assert property (@(negedge i_burst_clock)
    disable iff (!i_arst_n)
    !i_transfer_enable && enable_prev_r
    |=> word_r == $past(shift_r) && load_tgl_r != $past(load_tgl_r))
    else $error("load pulse did not capture the word");

  start_gate_a: assert property (@(negedge i_burst_clock)
    disable iff (!i_arst_n)
    !i_transfer_enable && enable_prev_r
    && shift_r[slpwm_pkg::START_POS] |=> !word_ok_r)
    else $error("high start bit accepted");

  length_gate_a: assert property (@(negedge i_burst_clock)
    disable iff (!i_arst_n)
    !i_transfer_enable && enable_prev_r
    && (count_r != slpwm_pkg::WORD_BITS_C || over_r) |=> !word_ok_r)
    else $error("word of wrong length accepted");

  ////////////////////////////////////////////////////////////////////////////
  // crossing into oscillator domain

  logic [2:0] tgl_sync_r;
  logic [1:0] pin_a_sync_r;
  logic [1:0] pin_b_sync_r;
  logic [1:0] glitch_sync_r;
  logic load_pulse;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tgl_sync_r <= 3'h0;
      pin_a_sync_r <= 2'h0;
      pin_b_sync_r <= 2'h0;
      glitch_sync_r <= 2'h0;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], load_tgl_r};
      pin_a_sync_r <= {pin_a_sync_r[0], i_device_addr_pin_a};
      pin_b_sync_r <= {pin_b_sync_r[0], i_device_addr_pin_b};
      glitch_sync_r <= {glitch_sync_r[0], i_supply_glitch};
    end
  end

  assign load_pulse = tgl_sync_r[2] ^ tgl_sync_r[1];

  // the word changes on the same link edge as its toggle, which needs two oscillator edges to be seen here,
  // so the level registers read it without a multi-bit race
  load_once_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    load_pulse |=> !load_pulse)
    else $error("load pulse longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // internal reset: one cycle at power up, held while a glitch lasts

  logic por_done_r;
  logic int_reset;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      por_done_r <= 1'b0;
    end else begin
      por_done_r <= 1'b1;
    end
  end

  // a glitch holds the reset for as long as the synced pin stays high
  assign int_reset = !por_done_r || glitch_sync_r[1];

  por_pulse_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !por_done_r |=> por_done_r)
    else $error("power-up reset not one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // level registers; word held stable since it settled before the synced toggle is seen

  logic [2:0] chan_sel;
  logic [5:0] level_val;
  logic addr_match;
  logic [5:0] level_r [slpwm_pkg::NUM_CHAN];

  assign chan_sel = word_r[slpwm_pkg::CHAN_LSB +: slpwm_pkg::CHAN_W];
  assign level_val = word_r[slpwm_pkg::LEVEL_LSB +: slpwm_pkg::LEVEL_W];
  assign addr_match = (word_r[slpwm_pkg::ADDR_A_POS] == pin_a_sync_r[1])
    && (word_r[slpwm_pkg::ADDR_B_POS] == pin_b_sync_r[1]);

  logic [5:0] phase_r;

  genvar g;
  generate
    for (g = 0; g < slpwm_pkg::NUM_CHAN; g++) begin : g_chan
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          level_r[g] <= slpwm_pkg::LEVEL_RESET;
        end else if (int_reset) begin
          level_r[g] <= slpwm_pkg::LEVEL_RESET;
        end else if (load_pulse && word_ok_r && addr_match
                     && chan_sel == 3'(g + 1)) begin
          level_r[g] <= level_val;
        end
      end

      // high while phase <= level: v+1 of 64 cycles
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_level_output[g] <= 1'b0;
        end else begin
          o_level_output[g] <= (phase_r <= level_r[g]);
        end
      end

      // the first edge after reset still shows the forced-low output
      pwm_duty_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $past(i_arst_n)
        |-> o_level_output[g] == ($past(phase_r) <= $past(level_r[g])))
        else $error("pwm output does not follow level");

      load_chan_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        load_pulse && word_ok_r && addr_match && chan_sel == 3'(g + 1)
        && !int_reset |=> level_r[g] == $past(level_val))
        else $error("selected channel not loaded");

      hold_chan_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !int_reset && !(load_pulse && chan_sel == 3'(g + 1))
        |=> $stable(level_r[g]))
        else $error("unselected channel changed");

      chan_reset_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        int_reset |=> level_r[g] == slpwm_pkg::LEVEL_RESET)
        else $error("channel not mid-scale after reset");

      // top level equals the last phase, so the output never drops
      full_on_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $past(i_arst_n) && $past(level_r[g]) == slpwm_pkg::PERIOD_LAST
        |-> o_level_output[g])
        else $error("full-scale output dropped");

      zero_low_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $past(i_arst_n) && $past(level_r[g]) == 6'h00
        && $past(phase_r) != 6'h00 |-> !o_level_output[g])
        else $error("zero level high past first cycle");

      // whole-period tally of high cycles; judged only over a steady level
      logic [6:0] tally_r;
      logic [5:0] ref_r;
      logic steady_r;

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          ref_r <= 6'h00;
          steady_r <= 1'b0;
        end else if (phase_r == 6'h00) begin
          ref_r <= level_r[g];
          steady_r <= 1'b1;
        end else begin
          steady_r <= steady_r && (level_r[g] == ref_r);
        end
      end

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          tally_r <= 7'h00;
        end else if (phase_r == 6'h01) begin
          tally_r <= 7'(o_level_output[g]);
        end else begin
          tally_r <= tally_r + 7'(o_level_output[g]);
        end
      end

      duty_tally_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        phase_r == 6'h00 && steady_r
        |-> tally_r + 7'(o_level_output[g]) == 7'(ref_r) + 7'h01)
        else $error("high time is not level plus one");
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_r <= 6'h00;
    end else begin
      phase_r <= phase_r + 6'h01;
    end
  end

  assign o_buffered_osc_out = i_clk;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  period_wrap_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    phase_r == slpwm_pkg::PERIOD_LAST |=> phase_r == 6'h00)
    else $error("pwm period not 64");

  reset_level_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    int_reset |=> level_r[0] == slpwm_pkg::LEVEL_RESET
    && level_r[5] == slpwm_pkg::LEVEL_RESET)
    else $error("levels not mid-scale after reset");

  por_once_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    por_done_r |=> por_done_r)
    else $error("power-up reset repeated");

  bad_chan_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (chan_sel == 3'h0 || chan_sel == 3'h7) && !int_reset
    |=> $stable(level_r[0]) && $stable(level_r[5]))
    else $error("invalid channel loaded");

  load_ch1_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    load_pulse && word_ok_r && addr_match && chan_sel == 3'h1 && !int_reset
    |=> level_r[0] == $past(level_val))
    else $error("channel 1 not loaded");

  no_load_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !load_pulse && !int_reset |=> $stable(level_r[2]))
    else $error("level changed without load");

  addr_gate_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !addr_match && !int_reset |=> $stable(level_r[3]))
    else $error("foreign address loaded");

  reject_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !word_ok_r && !int_reset |=> $stable(level_r[1]))
    else $error("bad word loaded");

endmodule

// ==== tb_serial_loaded_six_channel_pwm.sv ====
// self-checking bench for the serial-loaded six-channel pwm
`timescale 1ns/1ns
module tb_serial_loaded_six_channel_pwm;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic glitch = 1'b0;
  logic addr_a = 1'b1;
  logic addr_b = 1'b0;
  wire logic bclk;
  wire logic en;
  wire logic dat;
  wire logic osc;
  wire logic [5:0] lv;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [6:0] cnt [6];
  logic [5:0] vals [6] = '{6'h00, 6'h3f, 6'h01, 6'h3e, 6'h15, 6'h2a};
  always #10 clk = ~clk;
  slpwm_host host (.o_burst_clock(bclk), .o_transfer_enable(en),
    .o_data(dat));
  slpwm_top DUT (.i_clk(clk), .i_arst_n(arst_n), .i_supply_glitch(glitch),
    .i_burst_clock(bclk), .i_transfer_enable(en), .i_data(dat),
    .i_device_addr_pin_a(addr_a), .i_device_addr_pin_b(addr_b),
    .o_buffered_osc_out(osc), .o_level_output(lv));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] mk(input logic [2:0] c,
    input logic [5:0] v);
    return {v, c, addr_b, addr_a, 1'b0};
  endfunction
  task automatic chk(input string what, input logic [6:0] e,
    input logic [6:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %0d got %0d", what, e, g);
    end
  endtask
  // any 64-cycle window holds one full period once settled
  task automatic measure();
    repeat (70) @(negedge clk);
    for (int c = 0; c < 6; c++) cnt[c] = 7'h00;
    repeat (64) begin
      @(negedge clk);
      for (int c = 0; c < 6; c++) cnt[c] = cnt[c] + 7'(lv[c]);
    end
  endtask
  task automatic all_equal(input logic [6:0] e);
    measure();
    for (int c = 0; c < 6; c++) chk("high count", e, cnt[c]);
  endtask
  task automatic all_loaded();
    measure();
    for (int c = 0; c < 6; c++)
      chk("high count", {1'b0, vals[c]} + 7'h01, cnt[c]);
  endtask
  task automatic t_reset();
    all_equal(7'h20);
    @(posedge clk);
    #1 chk("osc copy high", 7'h01, 7'(osc));
    @(negedge clk);
    #1 chk("osc copy low", 7'h00, 7'(osc));
  endtask
  task automatic t_load();
    for (int c = 0; c < 6; c++) begin
      host.send(mk(3'(c + 1), vals[c]), 12);
      repeat (10) @(negedge clk);
    end
    all_loaded();
  endtask
  task automatic t_refuse();
    logic [11:0] w;
    w = mk(3'h1, 6'h33);
    host.send(w, 11);
    repeat (10) @(negedge clk);
    host.send(w, 13);
    repeat (10) @(negedge clk);
    host.send(w | 12'h001, 12);
    repeat (10) @(negedge clk);
    host.send(w ^ 12'h002, 12);
    repeat (10) @(negedge clk);
    host.send(mk(3'h0, 6'h33), 12);
    repeat (10) @(negedge clk);
    host.send(mk(3'h7, 6'h33), 12);
    all_loaded();
  endtask
  // straps move: a word for the old address is refused, the new one loads
  task automatic t_addr();
    logic [11:0] w;
    w = mk(3'h2, 6'h11);
    addr_a = 1'b0;
    addr_b = 1'b1;
    repeat (4) @(negedge clk);
    host.send(w, 12);
    repeat (10) @(negedge clk);
    vals[1] = 6'h2d;
    host.send(mk(3'h2, 6'h2d), 12);
    all_loaded();
  endtask
  task automatic t_glitch();
    @(negedge clk) glitch = 1'b1;
    repeat (3) @(negedge clk);
    glitch = 1'b0;
    all_equal(7'h20);
  endtask
  task automatic conclude();
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_load();
    t_refuse();
    t_addr();
    t_glitch();
    conclude();
  end
endmodule
